// file: logic/sxs_exec.sv
/*
  Execution datapath for a slice of an 8-bit core: literal and file
  subtraction, subtraction with borrow, nibble exchange, direction load,
  literal and file xor, and sleep.  Instructions are issued by writing the
  instruction register over AXI4-Lite; the 128-byte file is reached through
  a register window.  Assumes a single clock aclk with a synchronous reset.
*/
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns

// Summary of operation
// RULE1: literal_minus_acc puts literal minus accumulator into the accumulator.
// RULE2: literal subtraction carry/nibble flag are 1 unless acc exceeds literal.
// RULE3: sleep clears powerdown_not and sets timeout_not.
// RULE4: sleep zeroes the watchdog counter and prescaler and stops the core.
// RULE5: file_minus_acc subtracts the accumulator from the addressed file byte.
// RULE6: file_minus_acc_borrow also subtracts the inverted carry as a borrow.
// RULE7: nibble_exchange swaps the two nibbles and leaves every flag alone.
// RULE8: destination bit 0 writes the accumulator, 1 writes the file byte.
// RULE9: direction_load copies the accumulator to port A, B or C for 5, 6, 7.
// RULE10: literal_xor_acc puts acc xor literal into acc, touching only zero.
// RULE11: file_xor_acc xors acc with the file byte to the chosen destination.
// RULE12: an instruction that touches zero sets it exactly when result is 0.
module sxs_exec
  import sxs_pkg::*;
(
  input  wire logic        aclk,              // core clock, 125 MHz
  input  wire logic        aresetn,           // synchronous reset, low
  input  wire logic        ce,                // clock enable, freezes state
  input  wire logic [11:0] s_axi_awaddr,      // write address
  input  wire logic        s_axi_awvalid,     // write address valid
  output logic             s_axi_awready,     // write address ready
  input  wire logic [31:0] s_axi_wdata,       // write data
  input  wire logic [3:0]  s_axi_wstrb,       // write byte strobes
  input  wire logic        s_axi_wvalid,      // write data valid
  output logic             s_axi_wready,      // write data ready
  output logic [1:0]       s_axi_bresp,       // write response
  output logic             s_axi_bvalid,      // write response valid
  input  wire logic        s_axi_bready,      // write response ready
  input  wire logic [11:0] s_axi_araddr,      // read address
  input  wire logic        s_axi_arvalid,     // read address valid
  output logic             s_axi_arready,     // read address ready
  output logic [31:0]      s_axi_rdata,       // read data
  output logic [1:0]       s_axi_rresp,       // read response
  output logic             s_axi_rvalid,      // read data valid
  input  wire logic        s_axi_rready,      // read data ready
  output logic [7:0]       port_a_direction,  // port A direction register
  output logic [7:0]       port_b_direction,  // port B direction register
  output logic [7:0]       port_c_direction,  // port C direction register
  output logic             asleep,            // core asleep, oscillator off
  output logic             powerdown_not,     // power-down status, low
  output logic             timeout_not,       // timeout status, low
  output logic [7:0]       watchdog_counter   // watchdog count
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0]        acc;
    logic              carry;
    logic              nbn;
    logic              zero;
    logic              pdn;
    logic              ton;
    sxs_core_t         core;
    logic [7:0]        wdog;
    logic [7:0]        wpre;
    logic [7:0]        dir_a;
    logic [7:0]        dir_b;
    logic [7:0]        dir_c;
    logic [127:0][7:0] fmem;
    logic              aw_have;
    logic [11:0]       aw_addr;
    logic              w_have;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } sxs_state_t;

  sxs_state_t s_reg;
  sxs_state_t s_next;

  // execution helpers, also watched by the assertions
  logic       ex_go;
  sxs_op_t    ex_op;
  logic       ex_dest;
  logic [6:0] ex_fa;
  logic [7:0] ex_lit;
  logic [7:0] f_val;
  logic [7:0] res_val;
  logic [9:0] sub_res;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  function automatic sxs_sel_t reg_sel(input logic [11:0] addr);
    sxs_sel_t sel;
    sel = SXS_SEL_NONE;
    if (addr[1:0] != 2'h0)
      sel = SXS_SEL_NONE;
    else if (addr[11:9] == SXS_FILE_TOP)
      sel = SXS_SEL_FILE;
    else
    begin
      case (addr)
        SXS_OFF_INSTR:  sel = SXS_SEL_INSTR;
        SXS_OFF_ACC:    sel = SXS_SEL_ACC;
        SXS_OFF_STATUS: sel = SXS_SEL_STATUS;
        SXS_OFF_WDOG:   sel = SXS_SEL_WDOG;
        SXS_OFF_DIR_A:  sel = SXS_SEL_DIR_A;
        SXS_OFF_DIR_B:  sel = SXS_SEL_DIR_B;
        SXS_OFF_DIR_C:  sel = SXS_SEL_DIR_C;
        default:        sel = SXS_SEL_NONE;
      endcase
    end
    return sel;
  endfunction

  // a minus b minus not-cin; carry out is the active-low borrow
  // returns {carry, nibble carry, difference}
  function automatic logic [9:0] sub_flags(input logic [7:0] a,
                                           input logic [7:0] b,
                                           input logic       cin);
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
    low  = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
    return {full[8], low[4], full[7:0]};
  endfunction

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  assign s_axi_awready = ce && !s_reg.aw_have;
  assign s_axi_wready  = ce && !s_reg.w_have;
  assign s_axi_arready = ce && !s_reg.rvalid;

  always_comb
  begin
    sxs_sel_t wsel;
    sxs_sel_t rsel;
    wsel    = reg_sel(s_reg.aw_addr);
    rsel    = reg_sel(s_axi_araddr);
    s_next  = s_reg;
    ex_go   = 1'b0;
    ex_op   = sxs_op_t'(s_reg.w_data[SXS_INSTR_OP_LSB +: 4]);
    ex_dest = s_reg.w_data[SXS_INSTR_DEST_BIT];
    ex_fa   = s_reg.w_data[SXS_INSTR_FA_LSB +: 7];
    ex_lit  = s_reg.w_data[SXS_INSTR_LIT_LSB +: 8];
    f_val   = s_reg.fmem[ex_fa];
    res_val = 8'h00;
    sub_res = 10'h000;

    // free-running watchdog; prescaler wrap advances the count
    s_next.wpre = s_reg.wpre + 8'h01;
    if (s_reg.wpre == 8'hFF)
      s_next.wdog = s_reg.wdog + 8'h01;

    // write channel: address and data are taken in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      s_next.aw_have = 1'b1;
      s_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      s_next.w_have = 1'b1;
      s_next.w_data = s_axi_wdata;
      s_next.w_strb = s_axi_wstrb;
    end
    if (s_reg.bvalid && s_axi_bready)
      s_next.bvalid = 1'b0;

    if (s_reg.aw_have && s_reg.w_have && !s_reg.bvalid)
    begin
      s_next.aw_have = 1'b0;
      s_next.w_have  = 1'b0;
      s_next.bvalid  = 1'b1;
      s_next.bresp   = SXS_RESP_OKAY;
      case (wsel)
        SXS_SEL_INSTR:
          // a sleeping core executes nothing
          ex_go = (s_reg.w_strb[2:0] == 3'h7) &&
                  (s_reg.core == SXS_CORE_RUN) && ce;
        SXS_SEL_ACC:
          if (s_reg.w_strb[0])
            s_next.acc = s_reg.w_data[7:0];
        SXS_SEL_STATUS:
        begin
          if (s_reg.w_strb[0])
          begin
            s_next.carry = s_reg.w_data[SXS_ST_CARRY];
            s_next.nbn   = s_reg.w_data[SXS_ST_NBN];
            s_next.zero  = s_reg.w_data[SXS_ST_ZERO];
          end
          // stands in for a wake event from outside the block
          if (s_reg.w_strb[1] && s_reg.w_data[SXS_ST_WAKE])
            s_next.core = SXS_CORE_RUN;
        end
        SXS_SEL_FILE:
          if (s_reg.w_strb[0])
            s_next.fmem[s_reg.aw_addr[8:2]] = s_reg.w_data[7:0];
        SXS_SEL_WDOG, SXS_SEL_DIR_A, SXS_SEL_DIR_B, SXS_SEL_DIR_C:
          s_next.bresp = SXS_RESP_OKAY;
        default:
          s_next.bresp = SXS_RESP_SLVERR;
      endcase
    end

    // instruction execution
    if (ex_go)
    begin
      case (ex_op)
        SXS_OP_LIT_SUB:
        begin
          sub_res      = sub_flags(ex_lit, s_reg.acc, 1'b1);       // [RULE1]
          res_val      = sub_res[7:0];
          s_next.acc   = res_val;                                  // [RULE1]
          s_next.carry = sub_res[9];                               // [RULE2]
          s_next.nbn   = sub_res[8];                               // [RULE2]
          s_next.zero  = (res_val == 8'h00);                       // [RULE12]
        end
        SXS_OP_FILE_SUB, SXS_OP_FILE_SUBB:
        begin
          // with borrow, a clear carry takes one more away
          if (ex_op == SXS_OP_FILE_SUBB)
            sub_res = sub_flags(f_val, s_reg.acc, s_reg.carry);   // [RULE6]
          else
            sub_res = sub_flags(f_val, s_reg.acc, 1'b1);          // [RULE5]
          res_val      = sub_res[7:0];
          s_next.carry = sub_res[9];                               // [RULE5]
          s_next.nbn   = sub_res[8];                               // [RULE5]
          s_next.zero  = (res_val == 8'h00);                       // [RULE12]
        end
        SXS_OP_SWAP:
          res_val = {f_val[3:0], f_val[7:4]};                      // [RULE7]
        SXS_OP_LIT_XOR:
        begin
          res_val     = s_reg.acc ^ ex_lit;                        // [RULE10]
          s_next.acc  = res_val;
          s_next.zero = (res_val == 8'h00);                        // [RULE12]
        end
        SXS_OP_FILE_XOR:
        begin
          res_val     = s_reg.acc ^ f_val;                         // [RULE11]
          s_next.zero = (res_val == 8'h00);                        // [RULE12]
        end
        SXS_OP_DIR_LOAD:
          // other operands fall outside 5..7 and are ignored
          case (ex_fa)
            SXS_DIR_SEL_A: s_next.dir_a = s_reg.acc;               // [RULE9]
            SXS_DIR_SEL_B: s_next.dir_b = s_reg.acc;               // [RULE9]
            SXS_DIR_SEL_C: s_next.dir_c = s_reg.acc;               // [RULE9]
            default:       s_next.dir_a = s_reg.dir_a;
          endcase
        SXS_OP_SLEEP:
        begin
          s_next.pdn  = 1'b0;                                      // [RULE3]
          s_next.ton  = 1'b1;                                      // [RULE3]
          s_next.wdog = SXS_RST_WDOG;                              // [RULE4]
          s_next.wpre = SXS_RST_WDOG;                              // [RULE4]
          s_next.core = SXS_CORE_ASLEEP;                           // [RULE4]
        end
        default:
          res_val = 8'h00;
      endcase
      // file-operand results go where the destination bit points
      if (ex_op == SXS_OP_FILE_SUB || ex_op == SXS_OP_FILE_SUBB ||
          ex_op == SXS_OP_SWAP || ex_op == SXS_OP_FILE_XOR)
      begin
        if (ex_dest)
          s_next.fmem[ex_fa] = res_val;                            // [RULE8]
        else
          s_next.acc = res_val;                                    // [RULE8]
      end
    end

    // read channel: data registered one cycle after the address
    if (s_reg.rvalid && s_axi_rready)
      s_next.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready)
    begin
      s_next.rvalid = 1'b1;
      s_next.rdata  = 32'h0000_0000;
      s_next.rresp  = SXS_RESP_OKAY;
      case (rsel)
        SXS_SEL_INSTR:  s_next.rdata = 32'h0000_0000;
        SXS_SEL_ACC:    s_next.rdata[7:0] = s_reg.acc;
        SXS_SEL_STATUS:
        begin
          s_next.rdata[SXS_ST_CARRY]  = s_reg.carry;
          s_next.rdata[SXS_ST_NBN]    = s_reg.nbn;
          s_next.rdata[SXS_ST_ZERO]   = s_reg.zero;
          s_next.rdata[SXS_ST_PDN]    = s_reg.pdn;
          s_next.rdata[SXS_ST_TON]    = s_reg.ton;
          s_next.rdata[SXS_ST_ASLEEP] = (s_reg.core == SXS_CORE_ASLEEP);
        end
        SXS_SEL_WDOG:
        begin
          s_next.rdata[7:0]                  = s_reg.wdog;
          s_next.rdata[SXS_WDOG_PRE_LSB +: 8] = s_reg.wpre;
        end
        SXS_SEL_DIR_A:  s_next.rdata[7:0] = s_reg.dir_a;
        SXS_SEL_DIR_B:  s_next.rdata[7:0] = s_reg.dir_b;
        SXS_SEL_DIR_C:  s_next.rdata[7:0] = s_reg.dir_c;
        SXS_SEL_FILE:   s_next.rdata[7:0] = s_reg.fmem[s_axi_araddr[8:2]];
        default:        s_next.rresp = SXS_RESP_SLVERR;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_reg         <= '0;
      s_reg.acc     <= SXS_RST_ACC;
      s_reg.carry   <= SXS_RST_FLAG;
      s_reg.nbn     <= SXS_RST_FLAG;
      s_reg.zero    <= SXS_RST_FLAG;
      s_reg.pdn     <= SXS_RST_STNOT;
      s_reg.ton     <= SXS_RST_STNOT;
      s_reg.core    <= SXS_CORE_RUN;
      s_reg.wdog    <= SXS_RST_WDOG;
      s_reg.wpre    <= SXS_RST_WDOG;
      s_reg.dir_a   <= SXS_RST_DIR;
      s_reg.dir_b   <= SXS_RST_DIR;
      s_reg.dir_c   <= SXS_RST_DIR;
      s_reg.fmem    <= {128{SXS_RST_FILE}};
    end
    else if (ce)
      s_reg <= s_next;
  end

  assign s_axi_bvalid     = s_reg.bvalid;
  assign s_axi_bresp      = s_reg.bresp;
  assign s_axi_rvalid     = s_reg.rvalid;
  assign s_axi_rdata      = s_reg.rdata;
  assign s_axi_rresp      = s_reg.rresp;
  assign port_a_direction = s_reg.dir_a;
  assign port_b_direction = s_reg.dir_b;
  assign port_c_direction = s_reg.dir_c;
  assign asleep           = (s_reg.core == SXS_CORE_ASLEEP);
  assign powerdown_not    = s_reg.pdn;
  assign timeout_not      = s_reg.ton;
  assign watchdog_counter = s_reg.wdog;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_lit_sub;
    @(posedge aclk) disable iff (!aresetn)
    ex_go && ex_op == SXS_OP_LIT_SUB |=>
      s_reg.acc == 8'($past(ex_lit) - $past(s_reg.acc));
  endproperty
  a_lit_sub: assert property (p_lit_sub) // [RULE1]
    else $error("literal subtraction result wrong");

  property p_lit_flags;
    @(posedge aclk) disable iff (!aresetn)
    ex_go && ex_op == SXS_OP_LIT_SUB |=>
      s_reg.carry == ($past(s_reg.acc) <= $past(ex_lit)) &&
      s_reg.nbn == ($past(s_reg.acc[3:0]) <= $past(ex_lit[3:0]));
  endproperty
  a_lit_flags: assert property (p_lit_flags) // [RULE2]
    else $error("literal subtraction flags wrong");

  property p_sleep_status;
    @(posedge aclk) disable iff (!aresetn)
    ex_go && ex_op == SXS_OP_SLEEP |=>
      !powerdown_not && timeout_not && asleep;
  endproperty
  a_sleep_status: assert property (p_sleep_status) // [RULE3]
    else $error("sleep status bits wrong");

  property p_sleep_wdog;
    @(posedge aclk) disable iff (!aresetn)
    ex_go && ex_op == SXS_OP_SLEEP |=>
      watchdog_counter == 8'h00 && s_reg.wpre == 8'h00;
  endproperty
  a_sleep_wdog: assert property (p_sleep_wdog) // [RULE4]
    else $error("watchdog not cleared by sleep");

  property p_file_sub;
    @(posedge aclk) disable iff (!aresetn)
    ex_go && ex_op == SXS_OP_FILE_SUB && ex_dest |=>
      s_reg.fmem[$past(ex_fa)] == 8'($past(f_val) - $past(s_reg.acc)) &&
      s_reg.carry == ($past(s_reg.acc) <= $past(f_val));
  endproperty
  a_file_sub: assert property (p_file_sub) // [RULE5]
    else $error("file subtraction wrong");

  property p_borrow;
    @(posedge aclk) disable iff (!aresetn)
    ex_go && ex_op == SXS_OP_FILE_SUBB && !ex_dest && !s_reg.carry |=>
      s_reg.acc == 8'($past(f_val) - $past(s_reg.acc) - 8'h01);
  endproperty
  a_borrow: assert property (p_borrow) // [RULE6]
    else $error("borrow not subtracted");

  property p_swap;
    @(posedge aclk) disable iff (!aresetn)
    ex_go && ex_op == SXS_OP_SWAP && !ex_dest |=>
      s_reg.acc == {$past(f_val[3:0]), $past(f_val[7:4])} &&
      $stable(s_reg.carry) && $stable(s_reg.nbn) && $stable(s_reg.zero);
  endproperty
  a_swap: assert property (p_swap) // [RULE7]
    else $error("nibble exchange wrong");

  property p_dest_file;
    @(posedge aclk) disable iff (!aresetn)
    ex_go && ex_op == SXS_OP_FILE_XOR && ex_dest |=> $stable(s_reg.acc);
  endproperty
  a_dest_file: assert property (p_dest_file) // [RULE8]
    else $error("accumulator written with destination 1");

  property p_dir;
    @(posedge aclk) disable iff (!aresetn)
    ex_go && ex_op == SXS_OP_DIR_LOAD && ex_fa == SXS_DIR_SEL_B |=>
      port_b_direction == $past(s_reg.acc) && $stable(port_a_direction);
  endproperty
  a_dir: assert property (p_dir) // [RULE9]
    else $error("direction load wrong");

  property p_lit_xor;
    @(posedge aclk) disable iff (!aresetn)
    ex_go && ex_op == SXS_OP_LIT_XOR |=>
      s_reg.acc == ($past(s_reg.acc) ^ $past(ex_lit)) &&
      $stable(s_reg.carry);
  endproperty
  a_lit_xor: assert property (p_lit_xor) // [RULE10]
    else $error("literal xor wrong");

  property p_file_xor;
    @(posedge aclk) disable iff (!aresetn)
    ex_go && ex_op == SXS_OP_FILE_XOR && !ex_dest |=>
      s_reg.acc == ($past(s_reg.acc) ^ $past(f_val)) && $stable(s_reg.nbn);
  endproperty
  a_file_xor: assert property (p_file_xor) // [RULE11]
    else $error("file xor wrong");

  property p_zero;
    @(posedge aclk) disable iff (!aresetn)
    ex_go && (ex_op == SXS_OP_LIT_SUB || ex_op == SXS_OP_FILE_XOR ||
              ex_op == SXS_OP_FILE_SUB) |=>
      s_reg.zero == ($past(res_val) == 8'h00);
  endproperty
  a_zero: assert property (p_zero) // [RULE12]
    else $error("zero flag wrong");

endmodule

// file: shared/sxs_pkg.sv
/*
  Package for the subtract / xor / swap / sleep execution block: register
  offsets, field positions, reset values, opcode and state encodings.
  Assumes a 12-bit AXI4-Lite byte address and 32-bit data.
*/
package sxs_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] SXS_OFF_INSTR   = 12'h000;
  localparam logic [11:0] SXS_OFF_ACC     = 12'h004;
  localparam logic [11:0] SXS_OFF_STATUS  = 12'h008;
  localparam logic [11:0] SXS_OFF_WDOG    = 12'h00C;
  localparam logic [11:0] SXS_OFF_DIR_A   = 12'h010;
  localparam logic [11:0] SXS_OFF_DIR_B   = 12'h014;
  localparam logic [11:0] SXS_OFF_DIR_C   = 12'h018;
  localparam logic [11:0] SXS_OFF_FILE    = 12'h400;
  localparam logic [2:0]  SXS_FILE_TOP    = 3'h2;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SXS_INSTR_OP_LSB   = 0;
  localparam int SXS_INSTR_DEST_BIT = 4;
  localparam int SXS_INSTR_FA_LSB   = 8;
  localparam int SXS_INSTR_LIT_LSB  = 16;
  localparam int SXS_ST_CARRY       = 0;
  localparam int SXS_ST_NBN         = 1;
  localparam int SXS_ST_ZERO        = 2;
  localparam int SXS_ST_PDN         = 3;
  localparam int SXS_ST_TON         = 4;
  localparam int SXS_ST_ASLEEP      = 5;
  localparam int SXS_ST_WAKE        = 8;
  localparam int SXS_WDOG_PRE_LSB   = 8;

  // ----------------------------------------------------------------
  // reset values and operand constants
  // ----------------------------------------------------------------
  localparam logic [7:0] SXS_RST_ACC     = 8'h00;
  localparam logic [7:0] SXS_RST_DIR     = 8'hFF;
  localparam logic [7:0] SXS_RST_WDOG    = 8'h00;
  localparam logic [7:0] SXS_RST_FILE    = 8'h00;
  localparam logic       SXS_RST_FLAG    = 1'b0;
  localparam logic       SXS_RST_STNOT   = 1'b1;
  localparam logic [6:0] SXS_DIR_SEL_A   = 7'h05;
  localparam logic [6:0] SXS_DIR_SEL_B   = 7'h06;
  localparam logic [6:0] SXS_DIR_SEL_C   = 7'h07;
  localparam logic [1:0] SXS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SXS_RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    SXS_OP_NOP       = 4'h0,
    SXS_OP_LIT_SUB   = 4'h1,
    SXS_OP_FILE_SUB  = 4'h2,
    SXS_OP_FILE_SUBB = 4'h3,
    SXS_OP_SWAP      = 4'h4,
    SXS_OP_DIR_LOAD  = 4'h5,
    SXS_OP_LIT_XOR   = 4'h6,
    SXS_OP_FILE_XOR  = 4'h7,
    SXS_OP_SLEEP     = 4'h8
  } sxs_op_t;

  typedef enum logic [0:0] {
    SXS_CORE_RUN    = 1'b0,
    SXS_CORE_ASLEEP = 1'b1
  } sxs_core_t;

  typedef enum logic [3:0] {
    SXS_SEL_NONE, SXS_SEL_INSTR, SXS_SEL_ACC, SXS_SEL_STATUS, SXS_SEL_WDOG,
    SXS_SEL_DIR_A, SXS_SEL_DIR_B, SXS_SEL_DIR_C, SXS_SEL_FILE
  } sxs_sel_t;

endpackage

// file: testbench/test_sxs_exec.sv
/*
  Self-checking bench for sxs_exec: issues each instruction over AXI4-Lite
  and compares results, flags, directions and sleep state.
  Assumes the register map and encodings of sxs_pkg.
*/
`timescale 1ns/1ns
module test_sxs_exec;
  import sxs_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        ce = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid, asleep, pdn, ton;
  logic [1:0]  bresp, rresp, b_v;
  logic [31:0] rdata, rd_v;
  logic [7:0]  dir_a, dir_b, dir_c, wdog;
  int          err_count = 0;
  int          total_checks = 0;

  always #4 aclk = ~aclk;

  sxs_exec i_sxs_exec (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .port_a_direction(dir_a), .port_b_direction(dir_b),
    .port_c_direction(dir_c), .asleep(asleep), .powerdown_not(pdn),
    .timeout_not(ton), .watchdog_counter(wdog));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic stop_test();
    if (err_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= s;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    // bready held until the response is sampled
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!(bready && bvalid));
    b_v = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd_v = rdata;
    rready <= 1'b0;
  endtask

  task automatic ex(input sxs_op_t op, input logic d,
                    input logic [6:0] f, input logic [7:0] k);
    wr(SXS_OFF_INSTR, {8'h00, k, 1'b0, f, 3'b000, d, op}, 4'hF);
  endtask

  function automatic logic [11:0] fa(input logic [6:0] f);
    return SXS_OFF_FILE + {3'b000, f, 2'b00};
  endfunction

  task automatic flags(input string nm, input logic [2:0] exp);
    rd(SXS_OFF_STATUS);
    chk(nm, {29'h0, rd_v[2:0]}, {29'h0, exp});
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_sub();
    wr(SXS_OFF_ACC, 32'h05, 4'h1);
    ex(SXS_OP_LIT_SUB, 1'b0, 7'h00, 8'h03);
    rd(SXS_OFF_ACC); chk("lit_acc", rd_v, 32'hFE);
    flags("lit_fl", 3'b000);
    ex(SXS_OP_LIT_SUB, 1'b0, 7'h00, 8'hFE);
    flags("lit_eq", 3'b111);
    wr(fa(7'h7F), 32'h20, 4'h1);
    wr(SXS_OFF_ACC, 32'h21, 4'h1);
    ex(SXS_OP_FILE_SUB, 1'b1, 7'h7F, 8'h00);
    rd(fa(7'h7F)); chk("fsub_f", rd_v, 32'hFF);
    rd(SXS_OFF_ACC); chk("fsub_a", rd_v, 32'h21);
    flags("fsub_fl", 3'b000);
    ex(SXS_OP_FILE_SUB, 1'b0, 7'h7F, 8'h00);
    rd(SXS_OFF_ACC); chk("fsub_w", rd_v, 32'hDE);
  endtask

  task automatic t_borrow();
    wr(fa(7'h01), 32'h10, 4'h1);
    wr(SXS_OFF_ACC, 32'h01, 4'h1);
    wr(SXS_OFF_STATUS, 32'h0, 4'h1);
    ex(SXS_OP_FILE_SUBB, 1'b1, 7'h01, 8'h00);
    rd(fa(7'h01)); chk("subb_f", rd_v, 32'h0E);
    flags("subb_fl", 3'b001);
    wr(SXS_OFF_ACC, 32'h0D, 4'h1);
    wr(SXS_OFF_STATUS, 32'h0, 4'h1);
    ex(SXS_OP_FILE_SUBB, 1'b0, 7'h01, 8'h00);
    rd(SXS_OFF_ACC); chk("subb_z", rd_v, 32'h00);
    flags("subb_zf", 3'b111);
  endtask

  task automatic t_swap_dir();
    wr(fa(7'h05), 32'hA5, 4'h1);
    wr(SXS_OFF_STATUS, 32'h5, 4'h1);
    ex(SXS_OP_SWAP, 1'b0, 7'h05, 8'h00);
    rd(SXS_OFF_ACC); chk("swap", rd_v, 32'h5A);
    flags("swap_fl", 3'b101);
    ex(SXS_OP_DIR_LOAD, 1'b0, 7'h05, 8'h00);
    chk("dir_a", {24'h0, dir_a}, 32'h5A);
    chk("dir_b", {24'h0, dir_b}, 32'hFF);
    ex(SXS_OP_DIR_LOAD, 1'b0, 7'h06, 8'h00);
    chk("dir_b", {24'h0, dir_b}, 32'h5A);
    ex(SXS_OP_DIR_LOAD, 1'b0, 7'h07, 8'h00);
    chk("dir_c", {24'h0, dir_c}, 32'h5A);
    flags("dir_fl", 3'b101);
  endtask

  task automatic t_xor();
    ex(SXS_OP_LIT_XOR, 1'b0, 7'h00, 8'h5A);
    rd(SXS_OFF_ACC); chk("xorl", rd_v, 32'h00);
    flags("xorl_fl", 3'b101);
    wr(SXS_OFF_ACC, 32'h0F, 4'h1);
    ex(SXS_OP_FILE_XOR, 1'b1, 7'h05, 8'h00);
    rd(fa(7'h05)); chk("xorf", rd_v, 32'hAA);
    flags("xorf_fl", 3'b001);
  endtask

  task automatic t_sleep();
    repeat (600) @(posedge aclk);
    ex(SXS_OP_SLEEP, 1'b0, 7'h00, 8'h00);
    chk("asleep", {31'h0, asleep}, 32'h1);
    chk("pd_n", {31'h0, pdn}, 32'h0);
    chk("to_n", {31'h0, ton}, 32'h1);
    chk("wdog", {24'h0, wdog}, 32'h00);
    rd(SXS_OFF_WDOG);
    chk("wpre", {31'h0, rd_v[15:8] < 8'h10}, 32'h1);
    // core stopped: instruction must not execute
    ex(SXS_OP_LIT_XOR, 1'b0, 7'h00, 8'hFF);
    rd(SXS_OFF_ACC); chk("slp_acc", rd_v, 32'h0F);
    wr(SXS_OFF_STATUS, 32'h100, 4'h2);
    chk("wake", {31'h0, asleep}, 32'h0);
    chk("wake_b", {30'h0, b_v}, {30'h0, SXS_RESP_OKAY});
    rd(12'h020); chk("unmap", {30'h0, rresp}, {30'h0, SXS_RESP_SLVERR});
    wr(12'h020, 32'h0, 4'h1);
    chk("unmap_b", {30'h0, b_v}, {30'h0, SXS_RESP_SLVERR});
  endtask

  // watchdog would step at least once in 300 cycles if not frozen
  task automatic t_hold();
    logic [7:0] w0;
    @(posedge aclk);
    ce <= 1'b0;
    @(posedge aclk);
    w0 = wdog;
    repeat (300) @(posedge aclk);
    chk("ce_hold", {24'h0, wdog}, {24'h0, w0});
    ce <= 1'b1;
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_sub();
    t_borrow();
    t_swap_dir();
    t_xor();
    t_hold();
    t_sleep();
    stop_test();
  end

  initial
  begin
    repeat (20000) @(posedge aclk);
    err_count++;
    stop_test();
  end
endmodule
